/* File: hw/brlw_loader_storage_block.sv */
// Boot storage unit with nibble PROM array and watchdog restart
// Operation
// - Up to 2048 bytes of readable non-volatile program storage.
// - One to sixteen PROM positions of 128 bytes; unfitted ones may be absent.
// - Each PROM is 256 nibble words; a byte spans two consecutive words.
// - 12-bit address register advances twice per data request.
// - Address clears on system clear and on command byte bit 5.
// - Upper address bits pick one PROM, lower bits pick a nibble word.
// - Latch first nibble, advance address, present latched plus new nibble.
// - Byte driven onto data lines only while the data request is active.
// - Watchdog expiry without reset sets the initialize flip-flop.
// - No interrupt request toward the processor bus.
// - Timeout 96 ms default, strap 16 to 256 ms, 1 ms tick.
// - Address increments on leading and trailing edge of data request.
// - Bus acknowledge withheld until the whole byte is assembled.
// - Disable switch makes the unit ignore addressing and look absent.
module brlw_loader_storage_block
   import brlw_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
) (
   input  wire logic               ref_clk,
   input  wire logic               rstn,
   input  wire logic               system_clear_line,
   input  wire logic               data_request_strobe,
   input  wire logic               commandStrobe,
   input  wire logic [BYTE_W-1:0]  commandByte,
   output logic      [BYTE_W-1:0]  muxDataOut,
   output logic                    muxDataOe,
   output logic                    bus_acknowledge_line,
   output logic                    processor_initialize_out,
   input  wire logic               unit_disable_switch,
   input  wire logic               watchdog_enable_switch,
   input  wire logic               forceInitSwitch,
   input  wire logic [3:0]         timeoutStrap,
   input  wire logic [REG_AW-1:0]  regAddr,
   input  wire logic [15:0]        regWdata,
   input  wire logic               regWr,
   input  wire logic               regRd,
   output logic      [15:0]        regRdata,
   output logic                    eventIrq
);
   // Pin synchronisers
   localparam int SN = 7;
   logic [SN-1:0] syncA;
   logic [SN-1:0] syncB;
   logic [BYTE_W-1:0] cmdA;
   logic [BYTE_W-1:0] cmdB;
   wire  [SN-1:0] pinIn = {forceInitSwitch, watchdog_enable_switch, unit_disable_switch,
                           commandStrobe, data_request_strobe, system_clear_line, 1'b0};
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         syncA <= '0;
         syncB <= '0;
         cmdA  <= '0;
         cmdB  <= '0;
      end else begin
         syncA <= pinIn;
         syncB <= syncA;
         cmdA  <= commandByte;
         cmdB  <= cmdA;
      end
   end
   logic sysClr, drS, cmdS, offS, wdSwS, initSwS;
   assign sysClr  = syncB[1];
   assign drS     = syncB[2];
   assign cmdS    = syncB[3];
   assign offS    = syncB[4];
   assign wdSwS   = syncB[5];
   assign initSwS = syncB[6];

   // Nibble storage array
   logic [NIB_W-1:0] romMem [MEM_WORDS];

   function automatic logic [NIB_W-1:0] romRead(input logic [ADDR_W-1:0] a,
                                                input logic [15:0] fit);
      romRead = fit[a[ADDR_W-1:8]] ? romMem[a] : '0;
   endfunction : romRead

   // Registered state
   brlw_state_e          state;
   logic [ADDR_W-1:0]    addr;
   logic [NIB_W-1:0]     nibLatch;
   logic [BYTE_W-1:0]    dataReg;
   logic                 ackReg;
   logic                 drPrev;
   logic                 cmdPrev;
   logic                 wdRun;
   logic                 initFf;
   logic [8:0]           msCount;
   logic [17:0]          tickCount;
   logic [3:0]           strap;
   logic                 strapTaken;
   logic [15:0]          fitted;
   logic [ADDR_W-1:0]    progAddr;
   logic [EV_W-1:0]      status;
   logic [EV_W-1:0]      mask;

   brlw_state_e          next_state;
   logic [ADDR_W-1:0]    next_addr;
   logic [NIB_W-1:0]     next_nibLatch;
   logic [BYTE_W-1:0]    next_dataReg;
   logic                 next_ackReg;
   logic                 next_wdRun;
   logic                 next_initFf;
   logic [8:0]           next_msCount;
   logic [17:0]          next_tickCount;
   logic [3:0]           next_strap;
   logic                 next_strapTaken;
   logic [15:0]          next_fitted;
   logic [ADDR_W-1:0]    next_progAddr;
   logic [EV_W-1:0]      next_status;
   logic [EV_W-1:0]      next_mask;
   logic [15:0]          next_regRdata;

   logic drRise, drFall, cmdRise, clrAll, timeout, byteDone;
   logic [8:0] limitMs;
   assign clrAll  = sysClr;
   assign drRise  = drS && !drPrev && !offS;
   assign drFall  = !drS && drPrev;
   assign cmdRise = cmdS && !cmdPrev && !offS;
   assign limitMs = 9'((32'(strap) + 1) * STEP_MS);

   // Byte assembly and watchdog
   always_comb begin
      next_state     = state;
      next_addr      = addr;
      next_nibLatch  = nibLatch;
      next_dataReg   = dataReg;
      next_ackReg    = ackReg;
      next_wdRun     = wdRun;
      next_initFf    = initFf;
      next_msCount   = msCount;
      next_tickCount = tickCount;
      next_strap     = strap;
      next_strapTaken = 1'b1;
      timeout        = 1'b0;
      byteDone       = 1'b0;
      if (!strapTaken) begin
         next_strap = timeoutStrap;
      end
      unique case (state)
         BRLW_IDLE: begin
            if (drRise) begin
               next_nibLatch = romRead(addr, fitted);
               next_addr     = addr + 12'h001;
               next_state    = BRLW_FETCH;
            end
         end
         BRLW_FETCH: begin
            next_dataReg = {nibLatch, romRead(addr, fitted)};
            next_ackReg  = 1'b1;
            byteDone     = 1'b1;
            next_state   = BRLW_HOLD;
         end
         BRLW_HOLD: begin
            if (!drS) begin
               next_ackReg = 1'b0;
               next_addr   = addr + 12'h001;
               next_state  = BRLW_IDLE;
            end
         end
         BRLW_TAIL: begin
            next_state = BRLW_IDLE;
         end
      endcase
      if (state == BRLW_FETCH && drFall) begin
         next_state = BRLW_HOLD;
      end
      if (cmdRise) begin
         next_msCount   = '0;
         next_tickCount = '0;
         if (cmdB[CMD_WD_RUN_BIT]) begin
            next_wdRun = 1'b1;
         end
         if (cmdB[CMD_ADDR_CLR_BIT]) begin
            next_addr = ADDR_RESET;
         end
      end else if (wdRun) begin
         if (tickCount == 18'(TICK_CYCLES - 1)) begin
            next_tickCount = '0;
            if (msCount + 9'h001 >= limitMs) begin
               next_msCount = '0;
               timeout      = 1'b1;
               if (wdSwS) begin
                  next_initFf = 1'b1;
               end
            end else begin
               next_msCount = msCount + 9'h001;
            end
         end else begin
            next_tickCount = tickCount + 18'h00001;
         end
      end
      if (initSwS) begin
         next_initFf = 1'b1;
      end
      if (clrAll) begin
         next_addr      = ADDR_RESET;
         next_initFf    = 1'b0;
         next_wdRun     = 1'b0;
         next_msCount   = '0;
         next_tickCount = '0;
         next_ackReg    = 1'b0;
         next_state     = BRLW_IDLE;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state      <= BRLW_IDLE;
         addr       <= ADDR_RESET;
         nibLatch   <= '0;
         dataReg    <= '0;
         ackReg     <= 1'b0;
         drPrev     <= 1'b0;
         cmdPrev    <= 1'b0;
         wdRun      <= 1'b0;
         initFf     <= 1'b0;
         msCount    <= '0;
         tickCount  <= '0;
         strap      <= STRAP_DEFAULT;
         strapTaken <= 1'b0;
      end else begin
         state      <= next_state;
         addr       <= next_addr;
         nibLatch   <= next_nibLatch;
         dataReg    <= next_dataReg;
         ackReg     <= next_ackReg;
         drPrev     <= drS;
         cmdPrev    <= cmdS;
         wdRun      <= next_wdRun;
         initFf     <= next_initFf;
         msCount    <= next_msCount;
         tickCount  <= next_tickCount;
         strap      <= next_strap;
         strapTaken <= next_strapTaken;
      end
   end

   // Bus outputs
   assign muxDataOut               = dataReg;
   assign muxDataOe                = ackReg && drS && !offS;
   assign bus_acknowledge_line     = ackReg && drS && !offS;
   assign processor_initialize_out = initFf;

   // Local register port
   always_comb begin
      next_fitted   = fitted;
      next_progAddr = progAddr;
      next_mask     = mask;
      next_status   = status;
      next_regRdata = '0;
      if (regRd) begin
         unique case (regAddr)
            REG_FITTED:   next_regRdata = fitted;
            REG_PROGADDR: next_regRdata = {4'h0, progAddr};
            REG_STATUS: begin
               next_regRdata = {14'h0000, status};
               next_status   = '0;
            end
            REG_MASK:     next_regRdata = {14'h0000, mask};
            REG_ADDRESS:  next_regRdata = {4'h0, addr};
            default:      next_regRdata = '0;
         endcase
      end
      if (regWr) begin
         unique case (regAddr)
            REG_FITTED:   next_fitted   = regWdata;
            REG_PROGADDR: next_progAddr = regWdata[ADDR_W-1:0];
            REG_PROGDATA: next_progAddr = progAddr + 12'h001;
            REG_MASK:     next_mask     = regWdata[EV_W-1:0];
            default:      next_mask     = mask;
         endcase
      end
      if (timeout) begin
         next_status[EV_TIMEOUT] = 1'b1;
      end
      if (byteDone) begin
         next_status[EV_BYTE] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         fitted   <= FITTED_RESET;
         progAddr <= '0;
         mask     <= '0;
         status   <= '0;
         regRdata <= '0;
      end else begin
         fitted   <= next_fitted;
         progAddr <= next_progAddr;
         mask     <= next_mask;
         status   <= next_status;
         regRdata <= next_regRdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (regWr && regAddr == REG_PROGDATA) begin
         romMem[progAddr] <= regWdata[NIB_W-1:0];
      end
   end

   // Local event line, never routed to the processor bus
   assign eventIrq = |(status & mask);
endmodule : brlw_loader_storage_block

/* File: hw/brlw_pkg.sv */
// Constants for the boot storage and watchdog unit
package brlw_pkg;
   localparam int          ADDR_W       = 12;
   localparam int          NIB_W        = 4;
   localparam int          BYTE_W       = 8;
   localparam int          ROM_COUNT    = 16;
   localparam int          ROM_WORDS    = 256;
   localparam int          MEM_WORDS    = ROM_COUNT * ROM_WORDS;
   localparam int          STORE_BYTES  = 2048;
   localparam int          CLK_MHZ      = 250;
   localparam int          TICK_US      = 1000;
   localparam int          TICK_CYC     = TICK_US * CLK_MHZ;
   localparam int          STEP_MS      = 16;
   localparam logic [3:0]  STRAP_DEFAULT = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
   localparam int          CMD_ADDR_CLR_BIT = 5;
   localparam int          CMD_WD_RUN_BIT   = 6;
   localparam int          REG_AW       = 3;
   localparam logic [2:0]  REG_FITTED   = 3'h0;
   localparam logic [2:0]  REG_PROGADDR = 3'h1;
   localparam logic [2:0]  REG_PROGDATA = 3'h2;
   localparam logic [2:0]  REG_STATUS   = 3'h3;
   localparam logic [2:0]  REG_MASK     = 3'h4;
   localparam logic [2:0]  REG_ADDRESS  = 3'h5;
   localparam logic [15:0] FITTED_RESET = 16'hffff;
   localparam int          EV_TIMEOUT   = 0;
   localparam int          EV_BYTE      = 1;
   localparam int          EV_W         = 2;
   typedef enum logic [3:0] {
      BRLW_IDLE  = 4'b0001,
      BRLW_FETCH = 4'b0010,
      BRLW_HOLD  = 4'b0100,
      BRLW_TAIL  = 4'b1000
   } brlw_state_e;
endpackage : brlw_pkg

/* File: tb/brlw_assertions.sv */
// Port checker for the boot storage and watchdog unit
module brlw_checker
   import brlw_pkg::*;
(
   input wire logic              ref_clk,
   input wire logic              rstn,
   input wire logic              system_clear_line,
   input wire logic              data_request_strobe,
   input wire logic              unit_disable_switch,
   input wire logic              watchdog_enable_switch,
   input wire logic              forceInitSwitch,
   input wire logic [BYTE_W-1:0] muxDataOut,
   input wire logic              muxDataOe,
   input wire logic              bus_acknowledge_line,
   input wire logic              processor_initialize_out
);
   logic [2:0] clrAge;
   logic [2:0] next_clrAge;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // Cycles since system clear went low
   always_comb begin
      next_clrAge = (clrAge == 3'h7) ? clrAge : clrAge + 3'h1;
      if (system_clear_line) begin
         next_clrAge = 3'h0;
      end
   end
   always_ff @(posedge ref_clk) begin
      clrAge <= !rstn ? 3'h0 : next_clrAge;
   end
   a_oe_ack: assert property (muxDataOe == bus_acknowledge_line)
      else $error("drive enable differs from acknowledge");
   a_ack_latency: assert property (($rose(data_request_strobe) && !unit_disable_switch
      && !bus_acknowledge_line) |-> ##[3:5] bus_acknowledge_line)
      else $error("acknowledge not within bound");
   a_ack_drop: assert property ($fell(data_request_strobe) |-> ##[1:4] !bus_acknowledge_line)
      else $error("acknowledge outlives request");
   a_ack_needs_dr: assert property (bus_acknowledge_line |->
      $past(data_request_strobe, 2) || $past(data_request_strobe, 3))
      else $error("acknowledge without request");
   a_absent_off: assert property (unit_disable_switch && $past(unit_disable_switch, 4)
      |-> !muxDataOe)
      else $error("disabled unit drives bus");
   a_byte_stable: assert property (bus_acknowledge_line && $past(bus_acknowledge_line)
      |-> $stable(muxDataOut))
      else $error("byte changed during acknowledge");
   a_init_holds: assert property (processor_initialize_out && clrAge == 3'h7
      |=> processor_initialize_out)
      else $error("initialize dropped without clear");
   a_clear_init: assert property ((system_clear_line && !forceInitSwitch)[*4]
      |=> !processor_initialize_out)
      else $error("initialize survives system clear");
   a_init_cause: assert property ($rose(processor_initialize_out) |->
      $past(watchdog_enable_switch, 3) || $past(forceInitSwitch, 3))
      else $error("initialize without enable");
   c_ack: cover property ($rose(bus_acknowledge_line));
   c_init: cover property ($rose(processor_initialize_out));
   c_refused: cover property (unit_disable_switch && $rose(data_request_strobe));
endmodule : brlw_checker

bind brlw_loader_storage_block brlw_checker u_chk (.ref_clk, .rstn, .system_clear_line,
   .data_request_strobe, .unit_disable_switch, .watchdog_enable_switch, .forceInitSwitch,
   .muxDataOut, .muxDataOe, .bus_acknowledge_line, .processor_initialize_out);

/* File: tb/brlw_cpu_model.sv */
// Processor bus model issuing data requests and output commands
module brlw_cpu_model
   import brlw_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              bus_acknowledge_line,
   input  wire logic [BYTE_W-1:0] muxDataOut,
   output logic                   data_request_strobe,
   output logic                   commandStrobe,
   output logic      [BYTE_W-1:0] commandByte
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      data_request_strobe = 1'b0;
      commandStrobe = 1'b0;
      commandByte = 8'h00;
   end
   // Request held until acknowledge or for at most 12 cycles, then released with a gap
   task automatic xfer(output logic [BYTE_W-1:0] b, output logic ok);
      int n;
      ok = 1'b0;
      b = 8'h00;
      @(posedge ref_clk);
      data_request_strobe <= 1'b1;
      for (n = 0; n < 12 && !ok; n++) begin
         @(posedge ref_clk);
         if (bus_acknowledge_line === 1'b1) begin
            ok = 1'b1;
            b = muxDataOut;
         end
      end
      data_request_strobe <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask : xfer
   // Output command, byte held while strobe high
   task automatic command(input logic [BYTE_W-1:0] c);
      @(posedge ref_clk);
      commandByte <= c;
      commandStrobe <= 1'b1;
      repeat (3) @(posedge ref_clk);
      commandStrobe <= 1'b0;
      commandByte <= ~c;
      repeat (3) @(posedge ref_clk);
   endtask : command
endmodule : brlw_cpu_model

/* File: tb/brlw_loader_storage_block_tb.sv */
// Self-checking bench for the boot storage and watchdog unit
module brlw_loader_storage_block_tb
   import brlw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              ref_clk, rstn, system_clear_line, data_request_strobe, commandStrobe;
   logic [BYTE_W-1:0] commandByte, muxDataOut, b;
   logic              muxDataOe, bus_acknowledge_line, processor_initialize_out, ok;
   logic              unit_disable_switch, watchdog_enable_switch, forceInitSwitch;
   logic [3:0]        timeoutStrap;
   logic [REG_AW-1:0] regAddr;
   logic [15:0]       regWdata, regRdata, d;
   logic              regWr, regRd, eventIrq;
   int                mem[64];
   int                addr, i, nMismatch, checkCount;
   int                seed = 7;
   brlw_loader_storage_block #(.TICK_CYCLES(10)) dut (.ref_clk, .rstn, .system_clear_line,
      .data_request_strobe, .commandStrobe, .commandByte, .muxDataOut, .muxDataOe,
      .bus_acknowledge_line, .processor_initialize_out, .unit_disable_switch,
      .watchdog_enable_switch, .forceInitSwitch, .timeoutStrap, .regAddr, .regWdata,
      .regWr, .regRd, .regRdata, .eventIrq);
   brlw_cpu_model cpu (.ref_clk, .bus_acknowledge_line, .muxDataOut, .data_request_strobe,
      .commandStrobe, .commandByte);
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checkCount++;
      if (s !== e) begin
         nMismatch++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic regW(input logic [REG_AW-1:0] a, input logic [15:0] v);
      @(posedge ref_clk);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask : regW
   task automatic regR(input logic [REG_AW-1:0] a, output logic [15:0] v);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      @(posedge ref_clk);
      v = regRdata;
   endtask : regR
   task automatic results;
      $display("checks %0d mismatches %0d", checkCount, nMismatch);
      if (nMismatch == 0 && checkCount > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results
   initial begin
      {rstn, system_clear_line, unit_disable_switch, forceInitSwitch, regWr, regRd} = '0;
      {regAddr, regWdata, timeoutStrap} = '0;
      watchdog_enable_switch = 1'b1;
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      regW(REG_PROGADDR, 16'h0000);
      for (i = 0; i < 16; i++) begin
         mem[i] = $random(seed) & 15;
         regW(REG_PROGDATA, 16'(mem[i]));
      end
      cpu.command(8'h20);
      addr = 0;
      for (i = 0; i < 6; i++) begin
         cpu.xfer(b, ok);
         chk("ack", 16'(ok), 16'h0001);
         if (!ok) begin
            results();
         end
         chk("byte", 16'(b), 16'((mem[addr] << 4) | mem[addr + 1]));
         addr += 2;
      end
      regR(REG_ADDRESS, d);
      chk("address", d, 16'(addr));
      $display("test storage done");
      regW(REG_FITTED, 16'hfffe);
      cpu.command(8'h20);
      cpu.xfer(b, ok);
      chk("ackfit", 16'(ok), 16'h0001);
      chk("unfitted", 16'(b), 16'h0000);
      regW(REG_FITTED, 16'hffff);
      unit_disable_switch <= 1'b1;
      cpu.xfer(b, ok);
      chk("refused", 16'(ok), 16'h0000);
      regR(REG_ADDRESS, d);
      chk("held", d, 16'h0002);
      unit_disable_switch <= 1'b0;
      cpu.command(8'h00);
      regR(REG_ADDRESS, d);
      chk("kept", d, 16'h0002);
      cpu.command(8'h20);
      regR(REG_ADDRESS, d);
      chk("cleared", d, 16'h0000);
      $display("test address done");
      regW(REG_MASK, 16'h0001);
      regR(REG_STATUS, d);
      cpu.command(8'h40);
      repeat (100) @(posedge ref_clk);
      cpu.command(8'h40);
      repeat (16 * 10 - 14) @(posedge ref_clk);
      chk("early", 16'(processor_initialize_out), 16'h0000);
      repeat (30) @(posedge ref_clk);
      chk("expired", 16'(processor_initialize_out), 16'h0001);
      chk("irq", 16'(eventIrq), 16'h0001);
      regR(REG_STATUS, d);
      chk("status", 16'(d[EV_TIMEOUT]), 16'h0001);
      @(posedge ref_clk);
      chk("irqclr", 16'(eventIrq), 16'h0000);
      // Mid-run reset with a new strap and the enable switch off
      watchdog_enable_switch <= 1'b0;
      timeoutStrap <= 4'h2;
      rstn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      regW(REG_MASK, 16'h0001);
      cpu.command(8'h40);
      repeat (3 * STEP_MS * 10 - 14) @(posedge ref_clk);
      chk("strapearly", 16'(eventIrq), 16'h0000);
      repeat (30) @(posedge ref_clk);
      chk("strapirq", 16'(eventIrq), 16'h0001);
      chk("gated", 16'(processor_initialize_out), 16'h0000);
      forceInitSwitch <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk("forced", 16'(processor_initialize_out), 16'h0001);
      forceInitSwitch <= 1'b0;
      system_clear_line <= 1'b1;
      repeat (6) @(posedge ref_clk);
      system_clear_line <= 1'b0;
      @(posedge ref_clk);
      chk("sysclr", 16'(processor_initialize_out), 16'h0000);
      $display("test watchdog done");
      results();
   end
endmodule : brlw_loader_storage_block_tb
